// file: core/cba_cfg.svh
`ifndef CBA_CFG_SVH
`define CBA_CFG_SVH

// ----------------------------------------------------------------
// register map (byte addresses)
// ----------------------------------------------------------------
`define CBA_A_CTRL     8'h00
`define CBA_A_ATTN     8'h04
`define CBA_A_PTRSEL   8'h08
`define CBA_A_MAILBOX  8'h0c
`define CBA_A_LMTADDR  8'h10
`define CBA_A_LMTDATA  8'h14
`define CBA_A_QEMPTY   8'h18
`define CBA_A_STATUS   8'h1c
`define CBA_A_LAST     8'h1c

// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define CBA_B_PTROP    0
`define CBA_B_LIMIT_OP_REQUEST     1
`define CBA_B_DIR      8
`define CBA_B_BUSY     16
`define CBA_ATTN_RST   2'b11
`define CBA_IDX_W      4
`define CBA_LIM_W      9
`define CBA_NUM_Q      4'ha

// ----------------------------------------------------------------
// request classes, bit index = rank when not transmitting
// ----------------------------------------------------------------
`define CBA_C_RXDU     0
`define CBA_C_TXDU     1
`define CBA_C_REQD     2
`define CBA_C_INPUT_UNIT_DESCRIPTOR     3
`define CBA_C_CNF      4
`define CBA_C_PSPMV    5
`define CBA_C_PSPRD    6
`define CBA_C_LIMIT_OP_REQUEST     7
`define CBA_C_POINTER_OP_REQUEST     8
`define CBA_NCLS       9
`define CBA_NCHAN      7

// ----------------------------------------------------------------
// page geometry
// ----------------------------------------------------------------
`define CBA_MASK_1K    12'h3ff
`define CBA_MASK_4K    12'hfff
`define CBA_STEP_WORD  12'h004
`define CBA_STEP_DESC  12'h008

`endif

// file: core/cba_pkg.sv
`default_nettype none
package cba_pkg;

    // memory address: page number then offset within the page
    typedef struct packed {
        logic [15:0] page;
        logic [11:0] offset;
    } cba_addr_t;

    typedef enum logic [6:0] {
        CBA_IDLE = 7'h01,
        CBA_PRD  = 7'h02,
        CBA_PWT  = 7'h04,
        CBA_BUS  = 7'h08,
        CBA_PWB  = 7'h10,
        CBA_LOP  = 7'h20,
        CBA_LWT  = 7'h40
    } cba_fsm_t;

    typedef struct packed {
        cba_fsm_t fsm;
        logic [8:0] grant;
        logic [3:0] idx;
        cba_addr_t ptr;
        cba_addr_t nptr;
        cba_addr_t addr;
        logic [8:0] lim;
        logic two;
        logic word;
        logic mem_req;
        logic mem_wr;
        logic [31:0] mem_wdata;
        logic [31:0] chan_rdata;
        logic chan_beat;
        logic chan_done;
        logic bus_req;
        logic [1:0] attn;
        logic desc_4k;
        logic [3:0] ptr_sel;
        logic ptr_load;
        cba_addr_t mailbox;
        logic [3:0] lmt_idx;
        logic lmt_wr;
        logic [8:0] lmt_data;
        logic [9:0] qempty;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } cba_state_t;

endpackage
`default_nettype wire

// file: core/cba_mem.sv
`timescale 1ns/1ns
`default_nettype none
module cba_mem #(
    parameter int WIDTH = 28,
    parameter int DEPTH = 16,
    parameter int AW = 4
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [WIDTH-1:0] wdata,
    input wire logic [AW-1:0] raddr,
    output logic [WIDTH-1:0] rdata_r
);
    logic [WIDTH-1:0] mem [DEPTH];

    initial begin
        if (DEPTH > (1 << AW)) begin
            $error("cba_mem: depth does not fit address width");
        end
    end

    // ----------------------------------------------------------------
    // storage, no reset: contents are loaded by software before use
    // ----------------------------------------------------------------
    always_ff @(posedge pclk) begin
        if (we && (int'(waddr) < DEPTH)) begin
            mem[waddr] <= wdata;
        end
    end

    // registered read port; out-of-range entries read as zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_r <= '0;
        end else if (int'(raddr) < DEPTH) begin
            rdata_r <= mem[raddr];
        end else begin
            rdata_r <= '0;
        end
    end
endmodule // cba_mem
`default_nettype wire

// file: core/cba_channel_bus_arbiter.sv
`timescale 1ns/1ns
`default_nettype none
`include "cba_cfg.svh"
module cba_channel_bus_arbiter import cba_pkg::*; #(
    parameter int DATA_W = 32,
    parameter int PTR_DEPTH = 16,
    parameter int LIM_DEPTH = 10
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic transmitting,
    input wire logic [6:0] chan_req,
    input wire logic [6:0][3:0] chan_ptr_idx,
    input wire logic [31:0] chan_wdata,
    output logic [6:0] chan_grant,
    output logic chan_word,
    output logic [31:0] chan_rdata,
    output logic chan_beat,
    output logic chan_done,
    output logic bus_req,
    output logic mem_req,
    output logic mem_wr,
    output logic [27:0] mem_addr,
    output logic [31:0] mem_wdata,
    input wire logic mem_ack,
    input wire logic [31:0] mem_rdata
);
    cba_state_t s_r;
    cba_state_t s_nxt;
    logic [27:0] ptr_rdata;
    logic [8:0] lim_rdata;
    logic [3:0] lim_raddr;
    logic ptr_we;
    logic lim_we;

    initial begin
        if (DATA_W != 32 || PTR_DEPTH != 16 || LIM_DEPTH != 10) begin
            $error("cba_channel_bus_arbiter: unsupported geometry");
        end
    end

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // lowest set bit wins; while sending, data fetch and data write trade places
    function automatic logic [8:0] cba_pick(input logic [8:0] p, input logic tx);
        logic [8:0] q;
        logic [8:0] w;
        q = p;
        w = '0;
        if (tx) begin
            q[`CBA_C_RXDU] = p[`CBA_C_TXDU];
            q[`CBA_C_TXDU] = p[`CBA_C_RXDU];
        end
        for (int i = `CBA_NCLS - 1; i >= 0; i--) begin
            if (q[i]) begin
                w = 9'h001 << i;
            end
        end
        cba_pick = w;
        if (tx) begin
            cba_pick[`CBA_C_RXDU] = w[`CBA_C_TXDU];
            cba_pick[`CBA_C_TXDU] = w[`CBA_C_RXDU];
        end
    endfunction

    // bump the offset, keeping the page and wrapping inside the page
    function automatic cba_addr_t cba_step(input cba_addr_t a, input logic [11:0] inc,
                                           input logic [11:0] mask);
        logic [11:0] off;
        off = a.offset + inc;
        cba_step.page = a.page;
        cba_step.offset = (a.offset & ~mask) | (off & mask);
    endfunction

    function automatic logic cba_is_desc(input logic [8:0] g);
        cba_is_desc = g[`CBA_C_REQD] | g[`CBA_C_INPUT_UNIT_DESCRIPTOR] | g[`CBA_C_CNF] | g[`CBA_C_PSPRD];
    endfunction

    // page mask for descriptor queues follows the software page choice
    function automatic logic [11:0] cba_mask(input logic [8:0] g, input logic desc_4k);
        if (cba_is_desc(g) && !desc_4k) begin
            cba_mask = `CBA_MASK_1K;
        end else begin
            cba_mask = `CBA_MASK_4K;
        end
    endfunction

    function automatic logic cba_hit(input logic [7:0] a);
        cba_hit = (a[1:0] == 2'b00) && (a <= `CBA_A_LAST);
    endfunction

    // ----------------------------------------------------------------
    // pointer and limit storage
    // ----------------------------------------------------------------
    // entries 0..9 are the queue pointers, the rest data unit pointers
    assign ptr_we = (s_r.fsm == CBA_PWB);
    assign lim_we = (s_r.fsm == CBA_LOP) && s_r.lmt_wr;
    assign lim_raddr = (s_r.fsm == CBA_LOP) ? s_r.lmt_idx : s_r.idx;

    cba_mem #(.WIDTH(28), .DEPTH(PTR_DEPTH), .AW(`CBA_IDX_W)) u_ptr_mem (
        .pclk(pclk),
        .presetn(presetn),
        .we(ptr_we),
        .waddr(s_r.idx),
        .wdata(s_r.nptr),
        .raddr(s_r.idx),
        .rdata_r(ptr_rdata)
    );

    cba_mem #(.WIDTH(`CBA_LIM_W), .DEPTH(LIM_DEPTH), .AW(`CBA_IDX_W)) u_lim_mem (
        .pclk(pclk),
        .presetn(presetn),
        .we(lim_we),
        .waddr(s_r.lmt_idx),
        .wdata(s_r.lmt_data),
        .raddr(lim_raddr),
        .rdata_r(lim_rdata)
    );

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        logic [8:0] pend;
        logic [8:0] win;
        logic [11:0] mask;
        logic setup;
        logic wr_acc;
        cba_addr_t p;
        pend = '0;
        win = '0;
        mask = '0;
        p = '0;
        s_nxt = s_r;
        s_nxt.chan_beat = 1'b0;
        s_nxt.chan_done = 1'b0;
        s_nxt.pready = 1'b0;
        s_nxt.pslverr = 1'b0;
        setup = psel && !penable;
        wr_acc = psel && penable && s_r.pready && pwrite && cba_hit(paddr);

        // pending jobs: a cleared job bit is a request from software
        pend[`CBA_NCHAN-1:0] = chan_req;
        pend[`CBA_C_LIMIT_OP_REQUEST] = !s_r.attn[`CBA_B_LIMIT_OP_REQUEST];
        pend[`CBA_C_POINTER_OP_REQUEST] = !s_r.attn[`CBA_B_PTROP];
        s_nxt.bus_req = |pend;

        // apb: setup cycle prepares the answer, first access cycle ends it
        if (setup) begin
            s_nxt.pready = 1'b1;
            s_nxt.pslverr = !cba_hit(paddr);
            case (paddr)
                `CBA_A_CTRL: s_nxt.prdata = {31'h0, s_r.desc_4k};
                `CBA_A_ATTN: s_nxt.prdata = {30'h0, s_r.attn};
                `CBA_A_PTRSEL: s_nxt.prdata = {23'h0, s_r.ptr_load, 4'h0, s_r.ptr_sel};
                `CBA_A_MAILBOX: s_nxt.prdata = {4'h0, s_r.mailbox};
                `CBA_A_LMTADDR: s_nxt.prdata = {23'h0, s_r.lmt_wr, 4'h0, s_r.lmt_idx};
                `CBA_A_LMTDATA: s_nxt.prdata = {23'h0, s_r.lmt_data};
                `CBA_A_QEMPTY: s_nxt.prdata = {22'h0, s_r.qempty};
                `CBA_A_STATUS: s_nxt.prdata = {15'h0, s_r.fsm != CBA_IDLE, 7'h0, s_r.grant};
                default: s_nxt.prdata = 32'h0;
            endcase
        end

        // software writes land before hardware sets, so a set wins
        if (wr_acc) begin
            case (paddr)
                `CBA_A_CTRL: s_nxt.desc_4k = pwdata[0];
                `CBA_A_ATTN: s_nxt.attn = s_r.attn & pwdata[1:0];
                `CBA_A_PTRSEL: begin
                    s_nxt.ptr_sel = pwdata[3:0];
                    s_nxt.ptr_load = pwdata[`CBA_B_DIR];
                end
                `CBA_A_MAILBOX: s_nxt.mailbox = pwdata[27:0];
                `CBA_A_LMTADDR: begin
                    s_nxt.lmt_idx = pwdata[3:0];
                    s_nxt.lmt_wr = pwdata[`CBA_B_DIR];
                end
                `CBA_A_LMTDATA: s_nxt.lmt_data = pwdata[8:0];
                `CBA_A_QEMPTY: s_nxt.qempty = s_r.qempty & ~pwdata[9:0];
                default: ;
            endcase
        end

        // job sequencer
        case (s_r.fsm)
            CBA_IDLE: begin
                s_nxt.grant = '0;
                win = cba_pick(pend, transmitting);
                // skip one cycle after a done so the requester can drop
                if (win != '0 && !s_r.chan_done) begin
                    s_nxt.grant = win;
                    s_nxt.idx = s_r.ptr_sel;
                    for (int i = 0; i < `CBA_NCHAN; i++) begin
                        if (win[i]) begin
                            s_nxt.idx = chan_ptr_idx[i];
                        end
                    end
                    if (win[`CBA_C_PSPMV]) begin
                        s_nxt.chan_done = 1'b1;
                    end else if (win[`CBA_C_LIMIT_OP_REQUEST]) begin
                        s_nxt.fsm = CBA_LOP;
                    end else begin
                        s_nxt.fsm = CBA_PRD;
                    end
                end
            end
            CBA_PRD: s_nxt.fsm = CBA_PWT;
            CBA_PWT: begin
                p = ptr_rdata;
                mask = cba_mask(s_r.grant, s_r.desc_4k);
                s_nxt.ptr = p;
                s_nxt.nptr = p;
                s_nxt.lim = lim_rdata;
                s_nxt.word = 1'b0;
                s_nxt.two = 1'b0;
                if (s_r.grant[`CBA_C_POINTER_OP_REQUEST]) begin
                    s_nxt.addr = s_r.mailbox;
                    s_nxt.mem_wr = !s_r.ptr_load;
                end else if (cba_is_desc(s_r.grant)) begin
                    s_nxt.two = 1'b1;
                    s_nxt.nptr = cba_step(p, `CBA_STEP_DESC, mask);
                    if (s_r.grant[`CBA_C_INPUT_UNIT_DESCRIPTOR] || s_r.grant[`CBA_C_CNF]) begin
                        s_nxt.addr = p;
                        s_nxt.mem_wr = 1'b1;
                    end else begin
                        s_nxt.addr = cba_step(p, `CBA_STEP_DESC, mask);
                        s_nxt.mem_wr = 1'b0;
                    end
                end else begin
                    s_nxt.addr = p;
                    s_nxt.nptr = cba_step(p, `CBA_STEP_WORD, mask);
                    s_nxt.mem_wr = s_r.grant[`CBA_C_RXDU];
                end
                s_nxt.fsm = CBA_BUS;
            end
            CBA_BUS: begin
                if (!s_r.mem_req) begin
                    s_nxt.mem_req = 1'b1;
                    if (s_r.grant[`CBA_C_POINTER_OP_REQUEST]) begin
                        s_nxt.mem_wdata = {4'h0, s_r.ptr};
                    end else begin
                        s_nxt.mem_wdata = chan_wdata;
                    end
                end else if (mem_ack) begin
                    s_nxt.mem_req = 1'b0;
                    if (!s_r.mem_wr) begin
                        if (s_r.grant[`CBA_C_POINTER_OP_REQUEST]) begin
                            s_nxt.nptr = mem_rdata[27:0];
                        end else begin
                            s_nxt.chan_rdata = mem_rdata;
                            s_nxt.chan_beat = 1'b1;
                        end
                    end
                    if (s_r.two && !s_r.word) begin
                        s_nxt.word = 1'b1;
                        s_nxt.addr = cba_step(s_r.addr, `CBA_STEP_WORD, `CBA_MASK_4K);
                    end else begin
                        s_nxt.fsm = CBA_PWB;
                    end
                end
            end
            CBA_PWB: begin
                // pointer written back by the storage port this cycle
                mask = cba_mask(s_r.grant, s_r.desc_4k);
                if (cba_is_desc(s_r.grant) && s_r.idx < `CBA_NUM_Q) begin
                    if ((s_r.nptr.offset & mask) >> 3 == {3'h0, s_r.lim}) begin
                        s_nxt.qempty[s_r.idx] = 1'b1;
                    end
                end
                if (s_r.grant[`CBA_C_POINTER_OP_REQUEST]) begin
                    s_nxt.attn[`CBA_B_PTROP] = 1'b1;
                end else begin
                    s_nxt.chan_done = 1'b1;
                end
                s_nxt.fsm = CBA_IDLE;
            end
            CBA_LOP: s_nxt.fsm = CBA_LWT;
            CBA_LWT: begin
                if (!s_r.lmt_wr) begin
                    s_nxt.lmt_data = lim_rdata;
                end
                s_nxt.attn[`CBA_B_LIMIT_OP_REQUEST] = 1'b1;
                s_nxt.fsm = CBA_IDLE;
            end
            default: s_nxt.fsm = CBA_IDLE;
        endcase
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= '0;
            s_r.fsm <= CBA_IDLE;
            s_r.attn <= `CBA_ATTN_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    // outputs straight from the state register
    assign prdata = s_r.prdata;
    assign pready = s_r.pready;
    assign pslverr = s_r.pslverr;
    assign chan_grant = s_r.grant[`CBA_NCHAN-1:0];
    assign chan_word = s_r.word;
    assign chan_rdata = s_r.chan_rdata;
    assign chan_beat = s_r.chan_beat;
    assign chan_done = s_r.chan_done;
    assign bus_req = s_r.bus_req;
    assign mem_req = s_r.mem_req;
    assign mem_wr = s_r.mem_wr;
    assign mem_addr = s_r.addr;
    assign mem_wdata = s_r.mem_wdata;
endmodule // cba_channel_bus_arbiter
`default_nettype wire

// file: tb/cba_arb_properties.sv
`timescale 1ns/1ns
`default_nettype none
// ------------
// arbiter port properties
// ------------
module cba_arb_props (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic transmitting,
    input wire logic [6:0] chan_req,
    input wire logic [6:0] chan_grant,
    input wire logic chan_word,
    input wire logic [31:0] chan_rdata,
    input wire logic chan_beat,
    input wire logic chan_done,
    input wire logic bus_req,
    input wire logic mem_req,
    input wire logic mem_wr,
    input wire logic [27:0] mem_addr,
    input wire logic [31:0] mem_wdata,
    input wire logic mem_ack,
    input wire logic [31:0] mem_rdata
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // grant, memory handshake and pulse relations
    property p_bus_req; (|chan_req) |=> bus_req; endproperty
    a_bus_req: assert property (p_bus_req) else $error("no bus request");
    property p_onehot; $onehot0(chan_grant); endproperty
    a_onehot: assert property (p_onehot) else $error("grant not one-hot");
    // lowest class index wins, except tx data which jumps to the top while sending
    property p_rank;
        $rose(|chan_grant) |-> chan_grant == (($past(transmitting) && $past(chan_req[1]))
            ? 7'h02 : $past(chan_req) & (~$past(chan_req) + 7'h01));
    endproperty
    a_rank: assert property (p_rank) else $error("wrong winner");
    property p_hold;
        mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_wr)
            && $stable(mem_wdata);
    endproperty
    a_hold: assert property (p_hold) else $error("request changed early");
    property p_gap; mem_ack |=> !mem_req; endproperty
    a_gap: assert property (p_gap) else $error("no idle gap");
    property p_done; chan_done |=> !chan_done && chan_grant == 7'h00; endproperty
    a_done: assert property (p_done) else $error("grant held after done");
    // second descriptor word sits right after the first
    property p_word;
        mem_ack && !chan_word && (|(chan_grant & 7'h5c)) |=> chan_word
            && mem_addr == $past(mem_addr) + 28'h4;
    endproperty
    a_word: assert property (p_word) else $error("bad second word");
    property p_beat;
        mem_ack && !mem_wr && (|chan_grant) |=> chan_beat && chan_rdata == $past(mem_rdata);
    endproperty
    a_beat: assert property (p_beat) else $error("read word lost");
    c_tx_top: cover property (chan_done && chan_grant[1] && transmitting);
    c_pool: cover property (chan_done && chan_grant[5]);
    c_read: cover property (chan_beat);
endmodule // cba_arb_props

bind cba_channel_bus_arbiter cba_arb_props cba_arb_props_inst (.pclk, .presetn,
    .transmitting, .chan_req, .chan_grant, .chan_word, .chan_rdata, .chan_beat, .chan_done,
    .bus_req, .mem_req, .mem_wr, .mem_addr, .mem_wdata, .mem_ack, .mem_rdata);
`default_nettype wire

// file: tb/cba_host_mem.sv
`timescale 1ns/1ns
`default_nettype none
// ------------
// host memory model
// ------------
module cba_host_mem (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic mem_req,
    input wire logic mem_wr,
    input wire logic [27:0] mem_addr,
    input wire logic [31:0] mem_wdata,
    output logic mem_ack,
    output logic [31:0] mem_rdata
);
    logic [31:0] mem [logic [27:0]];
    int gap;
    // answers after 0..3 cycles; data is scrambled outside the ack cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_ack <= 1'b0;
            mem_rdata <= 32'h0;
            gap <= 0;
        end else if (mem_req && !mem_ack && gap == 0) begin
            if (mem_wr)
                mem[mem_addr] = mem_wdata;
            mem_rdata <= mem.exists(mem_addr) ? mem[mem_addr] : {4'h0, mem_addr};
            mem_ack <= 1'b1;
            gap <= $urandom % 4;
        end else begin
            mem_ack <= 1'b0;
            mem_rdata <= ~mem_rdata;
            gap <= (mem_req && !mem_ack) ? gap - 1 : gap;
        end
    end
endmodule // cba_host_mem
`default_nettype wire

// file: tb/tb_cba_channel_bus_arbiter.sv
`timescale 1ns/1ns
`default_nettype none
`include "cba_cfg.svh"
// ------------
// arbiter bench
// ------------
module tb_cba_channel_bus_arbiter;
    localparam logic [27:0] MB = 28'h00ff000;
    logic pclk, presetn, psel, penable, pwrite, transmitting, pready, pslverr, rd_e;
    logic chan_word, chan_beat, chan_done, bus_req, mem_req, mem_wr, mem_ack;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, chan_wdata, chan_rdata, mem_wdata, mem_rdata, rd_v, rd_x;
    logic [31:0] wd [2];
    logic [6:0] chan_req, chan_grant, prev_g, drop;
    logic [6:0][3:0] chan_ptr_idx;
    logic [27:0] mem_addr, p;
    logic [11:0] nx;
    int num_errors, comparisons;
    assign chan_wdata = wd[chan_word];

    cba_channel_bus_arbiter cba_channel_bus_arbiter_inst (.pclk, .presetn, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .transmitting, .chan_req,
        .chan_ptr_idx, .chan_wdata, .chan_grant, .chan_word, .chan_rdata, .chan_beat,
        .chan_done, .bus_req, .mem_req, .mem_wr, .mem_addr, .mem_wdata, .mem_ack, .mem_rdata);
    cba_host_mem cba_host_mem_inst (.pclk, .presetn, .mem_req, .mem_wr, .mem_addr,
        .mem_wdata, .mem_ack, .mem_rdata);

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    task automatic tally_and_finish();
        $display("errors %0d of %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // a wait that runs too long ends the run as a failure
    task automatic guard(inout int k);
        k++;
        if (k > 2000) begin
            num_errors++;
            tally_and_finish();
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // pready is looked at mid-cycle, where it has settled; the next edge completes
        do begin
            @(negedge pclk);
            guard(k);
        end while (pready !== 1'b1);
        rd_v = prdata;
        rd_e = pslverr;
        @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdx(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd_v, e);
    endtask

    // clear one job bit, then poll until the block sets it again
    task automatic job(input int b);
        int k = 0;
        apb(1'b1, `CBA_A_ATTN, ~(32'h1 << b));
        do begin
            apb(1'b0, `CBA_A_ATTN, 32'h0);
            guard(k);
        end while (rd_v[b] !== 1'b1);
    endtask

    // load (ld=1) or store a pointer through the mailbox word
    task automatic ptr(input logic ld, input logic [3:0] i, input logic [27:0] v);
        cba_host_mem_inst.mem[MB] = {4'h0, v};
        apb(1'b1, `CBA_A_MAILBOX, {4'h0, MB});
        apb(1'b1, `CBA_A_PTRSEL, {23'h0, ld, 4'h0, i});
        job(0);
        rd_v = cba_host_mem_inst.mem[MB];
    endtask

    task automatic lim(input logic [3:0] i, input logic [8:0] v);
        apb(1'b1, `CBA_A_LMTDATA, {23'h0, v});
        apb(1'b1, `CBA_A_LMTADDR, {23'h0, 1'b1, 4'h0, i});
        job(1);
    endtask

    task automatic go(input logic [6:0] r);
        int k = 0;
        @(posedge pclk);
        chan_req <= r;
        do begin
            @(posedge pclk);
            guard(k);
        end while (chan_req !== 7'h00);
        repeat (3) @(posedge pclk);
    endtask

    // reference ranking: class index is rank, top two swap while sending
    function automatic logic [6:0] win(input logic [6:0] r, input logic t);
        int c;
        for (int i = 0; i < 7; i++) begin
            c = (t && i < 2) ? 1 - i : i;
            if (r[c])
                return 7'h01 << c;
        end
        return 7'h00;
    endfunction

    // outputs are looked at mid-cycle, clear of the edge that launches them
    always @(negedge pclk) begin
        if (chan_grant !== 7'h00 && prev_g === 7'h00)
            chk(32'(chan_grant), 32'(win(chan_req, transmitting)));
        if (chan_beat)
            chk(chan_rdata, rd_x);
        if (mem_ack && !mem_wr)
            rd_x <= mem_rdata;
        prev_g <= chan_grant;
        drop <= chan_done ? chan_grant : 7'h00;
    end

    // requesters drop at the edge after their done pulse
    always @(posedge pclk) begin
        if (drop !== 7'h00)
            chan_req <= chan_req & ~drop;
    end

    initial begin
        {presetn, psel, penable, pwrite, transmitting} = 5'h00;
        paddr = 8'h00;
        pwdata = 32'h0;
        chan_req = 7'h00;
        prev_g = 7'h00;
        drop = 7'h00;
        rd_x = 32'h0;
        wd = '{32'h0, 32'h0};
        chan_ptr_idx = {4'h6, 4'h5, 4'h4, 4'h3, 4'h2, 4'hb, 4'ha};
        num_errors = 0;
        comparisons = 0;
        void'($urandom(32'h4770));
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        rdx(`CBA_A_ATTN, {30'h0, `CBA_ATTN_RST});
        rdx(`CBA_A_CTRL, 32'h0);
        apb(1'b1, 8'h20, 32'hffffffff);
        chk({31'h0, rd_e}, 32'h1);
        for (int i = 0; i < 16; i++) begin
            p = 28'($urandom) & 28'hffffff8;
            if (i < 10)
                lim(4'(i), 9'h1ff);
            ptr(1'b1, 4'(i), p);
            ptr(1'b0, 4'(i), ~p);
            chk(rd_v, {4'h0, p});
        end
        // descriptor write at a page end: 1k page wraps to 0x400, 4k goes on to 0x800
        for (int k = 0; k < 2; k++) begin
            nx = k ? 12'h800 : 12'h400;
            p = {16'($urandom), 12'h7f8};
            wd <= '{$urandom, $urandom};
            apb(1'b1, `CBA_A_CTRL, 32'(k));
            lim(4'h3, k ? 9'h100 : 9'h000);
            ptr(1'b1, 4'h3, p);
            go(7'h08);
            chk(cba_host_mem_inst.mem[p], wd[0]);
            chk(cba_host_mem_inst.mem[p + 28'h4], wd[1]);
            ptr(1'b0, 4'h3, ~p);
            chk(rd_v, {4'h0, p[27:12], nx});
            rdx(`CBA_A_QEMPTY, 32'h8);
            apb(1'b1, `CBA_A_QEMPTY, 32'h8);
            rdx(`CBA_A_QEMPTY, 32'h0);
        end
        // data unit pages stay 4k even with 1k descriptor pages
        apb(1'b1, `CBA_A_CTRL, 32'h0);
        p = {16'($urandom), 12'hffc};
        ptr(1'b1, 4'ha, p);
        go(7'h01);
        chk(cba_host_mem_inst.mem[p], wd[0]);
        ptr(1'b0, 4'ha, ~p);
        chk(rd_v, {4'h0, p[27:12], 12'h000});
        for (int i = 0; i < 6; i++) begin
            transmitting <= i[0];
            go(i < 2 ? 7'h7f : 7'($urandom) | 7'h01);
        end
        tally_and_finish();
    end

    initial begin
        #300000;
        num_errors++;
        tally_and_finish();
    end
endmodule // tb_cba_channel_bus_arbiter
`default_nettype wire
